/* File: dgo_core.sv */
`timescale 1ns/1ps
//Behaviour
// - code equals input times gain+1 over 8192 plus offset minus 2000 hex
// - input word 14 bits, resets midscale
// - gain word 13 bits, resets all ones
// - offset word 14 bits, resets 2000 hex
// - converter code resets to midscale
// - out-of-range code clamps full scale or zero
// - forty channels, four groups of ten
// - each channel stores input, code, gain, offset
// - write changes only the addressed channel, or that channel in all four groups for group F hex
// - select bits choose input, offset, gain, special
// - busy low during calculation, outputs held meanwhile
// - load while calculating or while busy is held low from outside is remembered, done later
// - reset sequence restores all channel words
module dgo_core
  import dgo_pkg::*;
#(
  parameter int RST_CYC = RESET_SEQ_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_WR_N,
  input wire logic I_CS_N,
  input wire logic [dgo_pkg::AW-1:0] I_ADDR,
  input wire logic [dgo_pkg::DW-1:0] I_DATA,
  input wire logic I_TARGET_SEL_HI,
  input wire logic I_TARGET_SEL_LO,
  input wire logic I_LOAD_OUTPUTS_N,
  input wire logic I_BUSY_N,
  output logic O_BUSY_N,
  output logic O_BUSY_N_OE,
  output dgo_pkg::dgo_code_t O_CODE
);
  import dgo_pkg::*;

  dgo_st_s st_ff;
  dgo_st_s nxt_st;
  dgo_pin_s pins_in;
  dgo_chan_s calc_chan;
  logic [DW-1:0] calc_code;
  logic calc_over;
  logic calc_under;
  logic wr_evt;
  logic ld_evt;
  logic soft_rst;
  logic wr_one;
  logic [1:0] tgt;
  logic [3:0] grp;
  logic [3:0] chn;
  logic [IDX_W-1:0] wr_idx;

  assign pins_in = '{I_WR_N, I_CS_N, I_TARGET_SEL_HI, I_TARGET_SEL_LO,
                     I_LOAD_OUTPUTS_N, I_BUSY_N, I_ADDR, I_DATA};

  // one shared calculator walks the channels, trading speed for area
  assign calc_chan = st_ff.ch[st_ff.idx];

  dgo_chan_calc u_calc (
    .i_chan(calc_chan),
    .o_code(calc_code),
    .o_over(calc_over),
    .o_under(calc_under)
  );

  // pin events, taken from the second and third sync stages only
  always_comb begin
    wr_evt = st_ff.pin2.wr_n && !st_ff.pin3.wr_n && !st_ff.pin2.cs_n;
    ld_evt = st_ff.pin3.load_outputs_n && !st_ff.pin2.load_outputs_n;
    tgt = {st_ff.pin2.target_sel_hi, st_ff.pin2.target_sel_lo};
    grp = st_ff.pin2.addr[AW-1:ADDR_GRP_LSB];
    chn = st_ff.pin2.addr[ADDR_GRP_LSB-1:0];
    wr_one = wr_evt && (grp < 4'(NGRP)) && (chn < 4'(NPG));
    // widened before the multiply: group three times ten overflows a nibble
    wr_idx = IDX_W'(grp) * IDX_W'(NPG) + IDX_W'(chn);
    soft_rst = wr_evt && (tgt == TGT_SFR) && (st_ff.state != ST_INIT)
               && (st_ff.pin2.data == SFR_SOFT_RST);
  end

  always_comb begin
    int k;
    k = 0;
    nxt_st = st_ff;
    nxt_st.pin1 = pins_in;
    nxt_st.pin2 = st_ff.pin1;
    nxt_st.pin3 = st_ff.pin2;

    // host writes are taken while idle or calculating, never during init
    if (wr_evt && st_ff.state != ST_INIT && tgt != TGT_SFR) begin
      for (int g = 0; g < NGRP; g++) begin
        for (int c = 0; c < NPG; c++) begin
          k = g * NPG + c;
          if ((grp == 4'(g) || grp == GRP_ALL) && chn == 4'(c)) begin
            case (tgt)
              TGT_INPUT: nxt_st.ch[k].input_word = st_ff.pin2.data;
              TGT_OFFS: nxt_st.ch[k].offset_word = st_ff.pin2.data;
              TGT_GAIN: nxt_st.ch[k].gain_word = st_ff.pin2.data[GW-1:0];
              default: nxt_st.ch[k] = st_ff.ch[k];
            endcase
          end
        end
      end
    end

    case (st_ff.state)
      ST_INIT: begin
        // load strobes and writes are ignored until the sequence ends
        nxt_st.busy_oe = 1'b1;
        nxt_st.load_pend = 1'b0;
        nxt_st.ch = {NCH{CH_RST}};
        nxt_st.stage = {NCH{CODE_RST}};
        nxt_st.code = {NCH{CODE_RST}};
        if (st_ff.cnt >= CNT_W'(RST_CYC - 1)) begin
          nxt_st.state = ST_IDLE;
          nxt_st.busy_oe = 1'b0;
          nxt_st.cnt = '0;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      ST_IDLE: begin
        if (ld_evt || st_ff.load_pend) begin
          // an outside party holding busy low delays the load
          if (st_ff.pin2.busy_n) begin
            nxt_st.state = ST_CALC;
            nxt_st.idx = '0;
            nxt_st.busy_oe = 1'b1;
            nxt_st.load_pend = 1'b0;
          end else begin
            nxt_st.load_pend = 1'b1;
          end
        end
      end
      ST_CALC: begin
        nxt_st.busy_oe = 1'b1;
        nxt_st.stage[st_ff.idx] = calc_code;
        if (ld_evt) begin
          nxt_st.load_pend = 1'b1;
        end
        if (st_ff.idx == IDX_W'(NCH - 1)) begin
          // codes reach the converters together, only when all are done
          nxt_st.code = nxt_st.stage;
          nxt_st.state = ST_IDLE;
          nxt_st.busy_oe = 1'b0;
          nxt_st.idx = '0;
        end else begin
          nxt_st.idx = st_ff.idx + 1'b1;
        end
      end
      default: begin
        nxt_st.state = ST_INIT;
        nxt_st.cnt = '0;
      end
    endcase

    if (soft_rst) begin
      nxt_st.state = ST_INIT;
      nxt_st.cnt = '0;
      nxt_st.idx = '0;
      nxt_st.busy_oe = 1'b1;
      nxt_st.load_pend = 1'b0;
      nxt_st.ch = {NCH{CH_RST}};
      nxt_st.stage = {NCH{CODE_RST}};
      nxt_st.code = {NCH{CODE_RST}};
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_ff.state <= ST_INIT;
      st_ff.cnt <= '0;
      st_ff.idx <= '0;
      st_ff.load_pend <= 1'b0;
      st_ff.busy_oe <= 1'b1;
      st_ff.pin1 <= PIN_IDLE;
      st_ff.pin2 <= PIN_IDLE;
      st_ff.pin3 <= PIN_IDLE;
      st_ff.ch <= {NCH{CH_RST}};
      st_ff.stage <= {NCH{CODE_RST}};
      st_ff.code <= {NCH{CODE_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // open-drain busy: only ever pulls low
  assign O_BUSY_N = 1'b0;
  assign O_BUSY_N_OE = st_ff.busy_oe;
  assign O_CODE = st_ff.code;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  sequence s_calc_last;
    st_ff.state == ST_CALC && st_ff.idx == IDX_W'(NCH - 1) && !soft_rst;
  endsequence

  sequence s_load_go;
    st_ff.state == ST_IDLE && (ld_evt || st_ff.load_pend)
      && st_ff.pin2.busy_n && !soft_rst;
  endsequence

  a_clamp_high: assert property (
    calc_over |-> calc_code == CODE_FULL)
    else $error("overflow not clamped to full scale");

  a_clamp_low: assert property (
    calc_under |-> calc_code == '0)
    else $error("underflow not clamped to zero");

  a_calc_step: assert property (
    st_ff.state == ST_CALC && !soft_rst
    |=> st_ff.stage[$past(st_ff.idx)] == $past(calc_code))
    else $error("computed code not stored for channel");

  a_calc_commit: assert property (
    s_calc_last |=> st_ff.state == ST_IDLE && !st_ff.busy_oe
                    && st_ff.code == st_ff.stage)
    else $error("codes not committed at end of calculation");

  a_code_held: assert property (
    st_ff.state == ST_IDLE && !soft_rst |=> $stable(st_ff.code))
    else $error("converter codes changed outside calculation");

  a_busy_drive: assert property (
    st_ff.state != ST_IDLE |-> st_ff.busy_oe)
    else $error("busy not driven low while working");

  a_load_start: assert property (
    s_load_go |=> st_ff.state == ST_CALC && st_ff.idx == '0 ##1
                  st_ff.state == ST_CALC && st_ff.idx == IDX_W'(1))
    else $error("load did not start calculation");

  a_load_stored: assert property (
    ld_evt && st_ff.state == ST_CALC && !soft_rst |=> st_ff.load_pend)
    else $error("load during busy was lost");

  a_init_words: assert property (
    st_ff.state == ST_INIT |-> st_ff.ch == {NCH{CH_RST}}
                               && st_ff.code == {NCH{CODE_RST}})
    else $error("channel words not at defaults during init");

  a_init_ignore: assert property (
    st_ff.state == ST_INIT |=> !st_ff.load_pend)
    else $error("load accepted during init");

  a_gain_write: assert property (
    wr_one && tgt == TGT_GAIN && st_ff.state != ST_INIT
    |=> st_ff.ch[$past(wr_idx)].gain_word == $past(st_ff.pin2.data[GW-1:0]))
    else $error("gain write not applied to channel");

  a_offs_write: assert property (
    wr_one && tgt == TGT_OFFS && !soft_rst && st_ff.state != ST_INIT
    |=> st_ff.ch[$past(wr_idx)].offset_word == $past(st_ff.pin2.data))
    else $error("offset write not applied to channel");

  a_input_write: assert property (
    wr_one && tgt == TGT_INPUT && st_ff.state != ST_INIT
    |=> st_ff.ch[$past(wr_idx)].input_word == $past(st_ff.pin2.data))
    else $error("input write not applied to channel");

  a_store_quiet: assert property (
    st_ff.state != ST_INIT && !wr_evt && !soft_rst |=> $stable(st_ff.ch))
    else $error("channel words changed without a write");

  a_sfr_ignore: assert property (
    wr_evt && tgt == TGT_SFR && !soft_rst |=> $stable(st_ff.ch))
    else $error("special function write altered channel words");

  a_soft_restart: assert property (
    soft_rst |=> st_ff.state == ST_INIT && st_ff.cnt == '0 && st_ff.busy_oe)
    else $error("soft reset did not restart the init sequence");

  a_init_end: assert property (
    st_ff.state == ST_INIT && st_ff.cnt == CNT_W'(RST_CYC - 1)
    |=> st_ff.state == ST_IDLE && !st_ff.busy_oe)
    else $error("init sequence did not end on time");

  a_idle_quiet: assert property (
    st_ff.state == ST_IDLE |-> !st_ff.busy_oe)
    else $error("busy driven while idle");

  a_calc_walk: assert property (
    st_ff.state == ST_CALC && st_ff.idx != IDX_W'(NCH - 1) && !soft_rst
    |=> st_ff.state == ST_CALC && st_ff.idx == $past(st_ff.idx) + 1'b1)
    else $error("calculation skipped or left a channel");

  a_load_stall: assert property (
    st_ff.state == ST_IDLE && (ld_evt || st_ff.load_pend)
    && !st_ff.pin2.busy_n && !soft_rst
    |=> st_ff.state == ST_IDLE && st_ff.load_pend)
    else $error("load not held while busy wire low");

  // checked against plain arithmetic, not the calculator's own flags
  a_unity_pass: assert property (
    calc_chan.gain_word == GAIN_RST && calc_chan.offset_word == OFFS_ZERO
    |-> calc_code == calc_chan.input_word)
    else $error("unity gain and zero offset changed the code");

  a_clamp_full: assert property (
    calc_chan.input_word == CODE_FULL && calc_chan.gain_word == GAIN_RST
    && calc_chan.offset_word > OFFS_ZERO |-> calc_code == CODE_FULL)
    else $error("positive overflow not clamped to full scale");

  a_clamp_zero: assert property (
    calc_chan.input_word == '0 && calc_chan.offset_word < OFFS_ZERO
    |-> calc_code == '0)
    else $error("negative result not clamped to zero");

endmodule // dgo_core

/* File: dgo_pkg.sv */
package dgo_pkg;

  localparam int NCH = 40;
  localparam int NGRP = 4;
  localparam int NPG = 10;
  localparam int DW = 14;
  localparam int GW = 13;
  localparam int AW = 8;

  localparam logic [DW-1:0] INPUT_RST = 14'h2000;
  localparam logic [GW-1:0] GAIN_RST = 13'h1FFF;
  localparam logic [DW-1:0] OFFS_RST = 14'h2000;
  localparam logic [DW-1:0] CODE_RST = 14'h2000;
  localparam logic [DW-1:0] OFFS_ZERO = 14'h2000;
  localparam logic [DW-1:0] CODE_FULL = 14'h3FFF;
  localparam int PROD_SHIFT = 13;

  // two target-select bits, high bit first
  localparam logic [1:0] TGT_SFR = 2'h0;
  localparam logic [1:0] TGT_GAIN = 2'h1;
  localparam logic [1:0] TGT_OFFS = 2'h2;
  localparam logic [1:0] TGT_INPUT = 2'h3;

  // group field in the upper address nibble, channel in the lower one
  localparam int ADDR_GRP_LSB = 4;
  localparam logic [3:0] GRP_ALL = 4'hF;
  localparam logic [DW-1:0] SFR_SOFT_RST = 14'h0001;

  localparam int CLK_HZ = 20_000_000;
  localparam int RESET_SEQ_MS = 100;
  localparam int RESET_SEQ_CYC = CLK_HZ / 1000 * RESET_SEQ_MS;
  localparam int CNT_W = 22;
  localparam int IDX_W = 6;

  typedef logic [NCH-1:0][DW-1:0] dgo_code_t;

  typedef struct packed {
    logic [DW-1:0] input_word;
    logic [GW-1:0] gain_word;
    logic [DW-1:0] offset_word;
  } dgo_chan_s;

  localparam dgo_chan_s CH_RST = '{INPUT_RST, GAIN_RST, OFFS_RST};

  typedef struct packed {
    logic wr_n;
    logic cs_n;
    logic target_sel_hi;
    logic target_sel_lo;
    logic load_outputs_n;
    logic busy_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } dgo_pin_s;

  localparam dgo_pin_s PIN_IDLE = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1,
                                    8'h00, 14'h0000};

  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_CALC} dgo_state_e;

  typedef struct packed {
    dgo_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [IDX_W-1:0] idx;
    logic load_pend;
    logic busy_oe;
    dgo_pin_s pin1;
    dgo_pin_s pin2;
    dgo_pin_s pin3;
    dgo_chan_s [NCH-1:0] ch;
    dgo_code_t stage;
    dgo_code_t code;
  } dgo_st_s;

endpackage

/* File: dgo_chan_calc.sv */
`timescale 1ns/1ps
module dgo_chan_calc
  import dgo_pkg::*;
(
  input wire dgo_pkg::dgo_chan_s i_chan,
  output logic [dgo_pkg::DW-1:0] o_code,
  output logic o_over,
  output logic o_under
);
  logic [DW-1:0] gain_p1;
  logic [2*DW-1:0] prod;
  logic [DW:0] prod_q;
  logic signed [DW+2:0] sum;

  always_comb begin
    gain_p1 = {1'b0, i_chan.gain_word} + 14'h0001;
    prod = i_chan.input_word * gain_p1;
    // product truncated before the offset-binary offset is added
    prod_q = prod[2*DW-1:PROD_SHIFT];
    sum = $signed({2'b00, prod_q}) + $signed({3'b000, i_chan.offset_word})
          - $signed({3'b000, OFFS_ZERO});
    o_under = sum[DW+2];
    o_over = !sum[DW+2] && (sum[DW+1:DW] != 2'b00);
    if (o_under) begin
      o_code = '0;
    end else if (o_over) begin
      o_code = CODE_FULL;
    end else begin
      o_code = sum[DW-1:0];
    end
  end
endmodule // dgo_chan_calc

/* File: dgo_host.sv */
`timescale 1ns/1ps
module dgo_host
  import dgo_pkg::*;
(
  input wire logic i_clk,
  output logic o_wr_n,
  output logic o_cs_n,
  output logic [AW-1:0] o_addr,
  output logic [DW-1:0] o_data,
  output logic o_sel_hi,
  output logic o_sel_lo,
  output logic o_load_n
);
  initial begin
    o_wr_n = 1'b1;
    o_cs_n = 1'b1;
    o_addr = '0;
    o_data = '0;
    {o_sel_hi, o_sel_lo} = 2'h0;
    o_load_n = 1'b1;
  end
  // strobe held 3 clocks so the 3-stage sync always sees it
  task automatic wr(input logic [1:0] t, input logic [AW-1:0] a,
                    input logic [DW-1:0] d);
    @(posedge i_clk);
    #1;
    o_cs_n = 1'b0;
    {o_sel_hi, o_sel_lo} = t;
    o_addr = a;
    o_data = d;
    o_wr_n = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    o_wr_n = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    o_cs_n = 1'b1;
    // released bus shows a changed value, not the stale word
    o_addr = ~a;
    o_data = ~d;
  endtask
  task automatic ld();
    @(posedge i_clk);
    #1;
    o_load_n = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    o_load_n = 1'b1;
  endtask
endmodule // dgo_host

/* File: testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import dgo_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic ext_low = 0;
  logic wr_n, cs_n, hi, lo, ld_n, bsy, oe, busy_w;
  logic [AW-1:0] adr;
  logic [DW-1:0] dat;
  dgo_code_t code;
  logic [DW-1:0] mx[NCH];
  logic [GW-1:0] mm[NCH];
  logic [DW-1:0] mc[NCH];
  int bad_count = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  // open-drain busy wire with pull-up
  assign busy_w = oe ? bsy : !ext_low;
  dgo_host h(.i_clk(clk), .o_wr_n(wr_n), .o_cs_n(cs_n), .o_addr(adr),
    .o_data(dat), .o_sel_hi(hi), .o_sel_lo(lo), .o_load_n(ld_n));
  dgo_core #(.RST_CYC(20)) i_dut(.I_CLK_SYS(clk), .I_RST_N(rst_n),
    .I_WR_N(wr_n), .I_CS_N(cs_n), .I_ADDR(adr), .I_DATA(dat),
    .I_TARGET_SEL_HI(hi), .I_TARGET_SEL_LO(lo), .I_LOAD_OUTPUTS_N(ld_n),
    .I_BUSY_N(busy_w), .O_BUSY_N(bsy), .O_BUSY_N_OE(oe), .O_CODE(code));
  function automatic logic [DW-1:0] calc(input int x, input int m,
                                         input int c);
    int v;
    v = x * (m + 1) / 8192 + c - 8192;
    if (v > 16383) return CODE_FULL;
    if (v < 0) return '0;
    return v[DW-1:0];
  endfunction
  task automatic mrst();
    for (int i = 0; i < NCH; i++) begin
      mx[i] = INPUT_RST;
      mm[i] = GAIN_RST;
      mc[i] = OFFS_RST;
    end
  endtask
  task automatic w(input logic [1:0] t, input logic [AW-1:0] a,
                   input logic [DW-1:0] d);
    h.wr(t, a, d);
    for (int i = 0; i < NCH; i++)
      if ((a[7:4] == 4'hF || a[7:4] == i / NPG) && a[3:0] == i % NPG) begin
        if (t == TGT_INPUT) mx[i] = d;
        else if (t == TGT_OFFS) mc[i] = d;
        else if (t == TGT_GAIN) mm[i] = d[GW-1:0];
      end
    if (t == TGT_SFR && d == SFR_SOFT_RST) mrst();
  endtask
  task automatic wait_oe(input logic v, input int lim);
    int n;
    n = 0;
    while (oe !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic do_load(input bit issue);
    dgo_code_t snap;
    int n;
    bit chg;
    if (issue) fork h.ld(); join_none
    wait_oe(1'b1, 60);
    snap = code;
    n = 0;
    chg = 0;
    while (oe === 1'b1 && n < 100) begin
      if (code !== snap) chg = 1;
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(chg, 1'b0)
    `CHK(n, 40)
    for (int i = 0; i < NCH; i++)
      `CHK(code[i], calc(mx[i], mm[i], mc[i]))
  endtask
  task automatic t_chan();
    w(TGT_INPUT, 8'h05, 14'h3000);
    w(TGT_GAIN, 8'h05, 14'h0FFF);
    w(TGT_OFFS, 8'h05, 14'h2100);
    w(TGT_INPUT, 8'h23, 14'h1234);
    w(TGT_INPUT, 8'h0A, 14'h0111); // channel nibble out of range
    w(TGT_INPUT, 8'h45, 14'h0222); // group out of range
    do_load(1);
    $display("test chan done");
  endtask
  task automatic t_clamp();
    w(TGT_INPUT, 8'h00, 14'h3FFF);
    w(TGT_OFFS, 8'h00, 14'h3FFF);
    w(TGT_INPUT, 8'h39, 14'h0000);
    w(TGT_OFFS, 8'h39, 14'h0000);
    do_load(1);
    `CHK(code[0], CODE_FULL)
    `CHK(code[39], 14'h0000)
    $display("test clamp done");
  endtask
  task automatic t_pend();
    logic [DW-1:0] old;
    old = code[1];
    w(TGT_INPUT, 8'h01, 14'h0800);
    @(posedge clk);
    #1;
    ext_low = 1'b1;
    fork h.ld(); join_none
    repeat (30) @(posedge clk);
    #1;
    `CHK(oe, 1'b0)
    `CHK(code[1], old)
    ext_low = 1'b0;
    do_load(0);
    $display("test pend done");
  endtask
  task automatic t_bcast();
    w(TGT_INPUT, 8'hF7, 14'h1000);
    w(TGT_GAIN, 8'hF8, 14'h1000);
    do_load(1);
    $display("test bcast done");
  endtask
  task automatic t_soft();
    w(TGT_SFR, 8'h00, 14'h0002);
    `CHK(oe, 1'b0)
    w(TGT_SFR, 8'h00, SFR_SOFT_RST);
    wait_oe(1'b0, 100);
    do_load(1);
    $display("test soft done");
  endtask
  task automatic t_busy();
    w(TGT_INPUT, 8'h12, 14'h0321);
    fork h.ld(); join_none
    wait_oe(1'b1, 60);
    // second load lands while the first calculation is still running
    h.ld();
    wait_oe(1'b0, 60);
    `CHK(oe, 1'b0)
    do_load(0);
    $display("test busy done");
  endtask
  task automatic t_pinrst();
    w(TGT_OFFS, 8'h21, 14'h2345);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    mrst();
    @(posedge clk);
    #1;
    `CHK(oe, 1'b1)
    `CHK(code, {NCH{CODE_RST}})
    rst_n = 1'b1;
    wait_oe(1'b0, 100);
    `CHK(oe, 1'b0)
    do_load(1);
    $display("test pin reset done");
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    mrst();
    repeat (12) @(posedge clk);
    #1;
    `CHK(oe, 1'b1)
    `CHK(code, {NCH{CODE_RST}})
    `CHK(bsy, 1'b0)
    rst_n = 1'b1;
    wait_oe(1'b0, 100);
    `CHK(oe, 1'b0)
    do_load(1);
    $display("test reset done");
    t_chan();
    t_clamp();
    t_pend();
    t_bcast();
    t_soft();
    t_busy();
    t_pinrst();
    give_verdict();
  end
endmodule // testbench
